/* File: hw/dslg_pkg.sv */
package dslg_pkg;

  localparam int OPC_W = 8;
  localparam int REV_W = 16;
  localparam int CNT_W = 3;

  // Security command opcodes.
  localparam logic [7:0] OPC_SET_PW = 8'hf1;
  localparam logic [7:0] OPC_UNLOCK = 8'hf2;
  localparam logic [7:0] OPC_ERASE_PREP = 8'hf3;
  localparam logic [7:0] OPC_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] OPC_FREEZE = 8'hf5;
  localparam logic [7:0] OPC_DISABLE_PW = 8'hf6;

  // Commands that a locked device refuses; device configuration only with the sub-commands below.
  localparam logic [7:0] OPC_READ_SEC = 8'h20;
  localparam logic [7:0] OPC_READ_SEC_NR = 8'h21;
  localparam logic [7:0] OPC_READ_LONG = 8'h22;
  localparam logic [7:0] OPC_READ_LONG_NR = 8'h23;
  localparam logic [7:0] OPC_READ_SEC_EXT = 8'h24;
  localparam logic [7:0] OPC_READ_DMA_EXT = 8'h25;
  localparam logic [7:0] OPC_READ_DMAQ_EXT = 8'h26;
  localparam logic [7:0] OPC_READ_MUL_EXT = 8'h29;
  localparam logic [7:0] OPC_READ_LOG_EXT = 8'h2f;
  localparam logic [7:0] OPC_WRITE_SEC = 8'h30;
  localparam logic [7:0] OPC_WRITE_SEC_NR = 8'h31;
  localparam logic [7:0] OPC_WRITE_LONG = 8'h32;
  localparam logic [7:0] OPC_WRITE_LONG_NR = 8'h33;
  localparam logic [7:0] OPC_WRITE_SEC_EXT = 8'h34;
  localparam logic [7:0] OPC_WRITE_DMA_EXT = 8'h35;
  localparam logic [7:0] OPC_WRITE_DMAQ_EXT = 8'h36;
  localparam logic [7:0] OPC_SET_MAX_EXT = 8'h37;
  localparam logic [7:0] OPC_WRITE_MUL_EXT = 8'h39;
  localparam logic [7:0] OPC_WRITE_LOG_EXT = 8'h3f;
  localparam logic [7:0] OPC_VERIFY = 8'h40;
  localparam logic [7:0] OPC_VERIFY_NR = 8'h41;
  localparam logic [7:0] OPC_VERIFY_EXT = 8'h42;
  localparam logic [7:0] OPC_FORMAT_TRK = 8'h50;
  localparam logic [7:0] OPC_SERVICE = 8'ha2;
  localparam logic [7:0] OPC_DEV_CONFIG = 8'hb1;
  localparam logic [7:0] OPC_READ_MUL = 8'hc4;
  localparam logic [7:0] OPC_WRITE_MUL = 8'hc5;
  localparam logic [7:0] OPC_READ_DMAQ = 8'hc7;
  localparam logic [7:0] OPC_READ_DMA = 8'hc8;
  localparam logic [7:0] OPC_READ_DMA_NR = 8'hc9;
  localparam logic [7:0] OPC_WRITE_DMA = 8'hca;
  localparam logic [7:0] OPC_WRITE_DMA_NR = 8'hcb;
  localparam logic [7:0] OPC_WRITE_DMAQ = 8'hcc;
  localparam logic [7:0] OPC_SET_MAX = 8'hf9;

  // Device configuration sub-commands, carried in the feature field.
  localparam logic [7:0] FEAT_CFG_RESTORE = 8'hc0;
  localparam logic [7:0] FEAT_CFG_SET = 8'hc3;

  // Master password revision code range and shipping default.
  localparam logic [15:0] REV_MIN = 16'h0001;
  localparam logic [15:0] REV_MAX = 16'hfffe;
  localparam logic [15:0] REV_DEFAULT = 16'hfffe;

  // Mismatches allowed before unlock and erase unit are refused.
  localparam logic [2:0] ATTEMPT_LIMIT = 3'h5;

  // Security mode; BOOT is the one cycle in which stored settings load.
  typedef enum logic [2:0] {
    DSLG_BOOT = 3'b001,
    DSLG_LOCKED = 3'b010,
    DSLG_UNLOCKED = 3'b100
  } dslg_mode_e;

endpackage

/* File: hw/dslg_attempt_counter.sv */
`timescale 1ns/100ps
module dslg_attempt_counter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Events.
  input wire logic clear_req,
  input wire logic mismatch,
  // Status.
  output logic exhausted
);
  import dslg_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic exhausted_reg;
  logic exhausted_next;

  // The count saturates at the limit so it cannot wrap back below it.
  always_comb begin
    count_next = count_reg;
    exhausted_next = exhausted_reg;
    if (clear_req) begin
      count_next = '0;
      exhausted_next = 1'b0;
    end else if (mismatch && !exhausted_reg) begin
      count_next = count_reg + 3'h1;
      exhausted_next = (count_reg + 3'h1) == ATTEMPT_LIMIT;
    end
  end

  // Power-on reset clears both, as does a hard reset request.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= '0;
      exhausted_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      exhausted_reg <= exhausted_next;
    end
  end

  assign exhausted = exhausted_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  count_clear_a: assert property (clear_req |=> count_reg == 3'h0 && !exhausted)
    else $error("Hard reset did not clear the mismatch count.");
  fifth_sets_a: assert property (
    mismatch && !clear_req && count_reg == 3'h4 |=> exhausted)
    else $error("Fifth mismatch did not set the exhausted flag.");
  flag_sticky_a: assert property (exhausted && !clear_req |=> exhausted)
    else $error("Exhausted flag dropped without a reset.");

endmodule

/* File: hw/dslg_gate.sv */
`timescale 1ns/100ps
module dslg_gate (
  // Clock and resets.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hard_rst_req,
  // Stored security settings, restored at power on.
  input wire logic nv_user_pw_set,
  input wire logic nv_level_max,
  input wire logic [dslg_pkg::REV_W-1:0] nv_master_rev,
  // Command from the host controller.
  input wire logic cmd_valid,
  input wire logic [dslg_pkg::OPC_W-1:0] cmd_opcode,
  input wire logic [dslg_pkg::OPC_W-1:0] cmd_feature,
  input wire logic cmd_pw_master,
  input wire logic cmd_level_max,
  input wire logic [dslg_pkg::REV_W-1:0] cmd_master_rev,
  input wire logic cmd_pw_match,
  // Command answer.
  output logic cmd_done,
  output logic cmd_abort,
  output logic cmd_exec,
  output logic erase_start,
  // Security status.
  output logic mode_locked,
  output logic mode_frozen,
  output logic user_pw_set,
  output logic level_max,
  output logic [dslg_pkg::REV_W-1:0] id_word92,
  output logic unlock_attempts_exhausted_flag
);
  import dslg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command classification.

  // Commands refused while locked.
  function automatic logic locked_blocks(input logic [7:0] opc, input logic [7:0] feat);
    logic hit;
    hit = 1'b0;
    case (opc)
      OPC_READ_SEC, OPC_READ_SEC_NR, OPC_READ_LONG, OPC_READ_LONG_NR,
      OPC_READ_SEC_EXT, OPC_READ_DMA_EXT, OPC_READ_DMAQ_EXT, OPC_READ_MUL_EXT,
      OPC_READ_LOG_EXT, OPC_WRITE_SEC, OPC_WRITE_SEC_NR, OPC_WRITE_LONG,
      OPC_WRITE_LONG_NR, OPC_WRITE_SEC_EXT, OPC_WRITE_DMA_EXT, OPC_WRITE_DMAQ_EXT,
      OPC_SET_MAX_EXT, OPC_WRITE_MUL_EXT, OPC_WRITE_LOG_EXT, OPC_VERIFY,
      OPC_VERIFY_NR, OPC_VERIFY_EXT, OPC_FORMAT_TRK, OPC_SERVICE, OPC_READ_MUL,
      OPC_WRITE_MUL, OPC_READ_DMAQ, OPC_READ_DMA, OPC_READ_DMA_NR, OPC_WRITE_DMA,
      OPC_WRITE_DMA_NR, OPC_WRITE_DMAQ, OPC_SET_MAX, OPC_SET_PW, OPC_DISABLE_PW,
      OPC_FREEZE: begin
        hit = 1'b1;
      end
      OPC_DEV_CONFIG: begin
        hit = (feat == FEAT_CFG_RESTORE) || (feat == FEAT_CFG_SET);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Commands refused while frozen and unlocked: those that touch passwords or the lock.
  function automatic logic frozen_blocks(input logic [7:0] opc);
    return (opc == OPC_SET_PW) || (opc == OPC_UNLOCK) || (opc == OPC_ERASE_PREP) ||
      (opc == OPC_ERASE_UNIT) || (opc == OPC_DISABLE_PW);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Security state.

  dslg_mode_e mode_reg;
  dslg_mode_e mode_next;
  logic frozen_reg;
  logic frozen_next;
  logic user_pw_reg;
  logic user_pw_next;
  logic level_max_reg;
  logic level_max_next;
  logic [REV_W-1:0] rev_reg;
  logic [REV_W-1:0] rev_next;
  logic armed_reg;
  logic armed_next;
  logic done_reg;
  logic done_next;
  logic abort_reg;
  logic abort_next;
  logic exec_reg;
  logic exec_next;
  logic erase_reg;
  logic erase_next;
  logic mismatch;
  logic blocked;
  logic expired;

  dslg_attempt_counter u_attempts (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear_req(hard_rst_req),
    .mismatch(mismatch),
    .exhausted(expired)
  );

  // A filtered command is refused before any state is looked at, so the
  // abort path can never disturb the lock or the media.
  always_comb begin
    blocked = 1'b0;
    if (mode_reg == DSLG_LOCKED) begin
      blocked = locked_blocks(cmd_opcode, cmd_feature);
    end else if (frozen_reg) begin
      blocked = frozen_blocks(cmd_opcode);
    end
  end

  // One command is decided per cycle; a hard reset in the same cycle wins and
  // the command is dropped unanswered. A hard reset in the boot cycle lets the
  // stored settings load first, so a locked drive can never come up unlocked.
  always_comb begin
    mode_next = mode_reg;
    frozen_next = frozen_reg;
    user_pw_next = user_pw_reg;
    level_max_next = level_max_reg;
    rev_next = rev_reg;
    armed_next = armed_reg;
    done_next = 1'b0;
    abort_next = 1'b0;
    exec_next = 1'b0;
    erase_next = 1'b0;
    mismatch = 1'b0;
    if (hard_rst_req && mode_reg != DSLG_BOOT) begin
      mode_next = user_pw_reg ? DSLG_LOCKED : DSLG_UNLOCKED;
      armed_next = 1'b0;
    end else begin
      unique case (mode_reg)
        DSLG_BOOT: begin
          user_pw_next = nv_user_pw_set;
          level_max_next = nv_level_max;
          rev_next = nv_master_rev;
          mode_next = nv_user_pw_set ? DSLG_LOCKED : DSLG_UNLOCKED;
        end
        DSLG_LOCKED, DSLG_UNLOCKED: begin
          if (cmd_valid) begin
            done_next = 1'b1;
            armed_next = 1'b0;
            if (blocked) begin
              abort_next = 1'b1;
            end else begin
              case (cmd_opcode)
                OPC_SET_PW: begin
                  if (cmd_pw_master) begin
                    // Only the code changes; the lock stays as it is.
                    if (cmd_master_rev >= REV_MIN && cmd_master_rev <= REV_MAX) begin
                      rev_next = cmd_master_rev;
                    end
                  end else begin
                    user_pw_next = 1'b1;
                    level_max_next = cmd_level_max;
                  end
                end
                OPC_UNLOCK: begin
                  if (expired || (cmd_pw_master && level_max_reg)) begin
                    abort_next = 1'b1;
                  end else if (!cmd_pw_match) begin
                    abort_next = 1'b1;
                    mismatch = 1'b1;
                  end else begin
                    mode_next = DSLG_UNLOCKED;
                  end
                end
                OPC_ERASE_PREP: begin
                  armed_next = 1'b1;
                end
                OPC_ERASE_UNIT: begin
                  if (expired || !armed_reg) begin
                    abort_next = 1'b1;
                  end else if (!cmd_pw_match) begin
                    abort_next = 1'b1;
                    mismatch = 1'b1;
                  end else begin
                    erase_next = 1'b1;
                    mode_next = DSLG_UNLOCKED;
                    user_pw_next = 1'b0;
                  end
                end
                OPC_FREEZE: begin
                  frozen_next = 1'b1;
                end
                OPC_DISABLE_PW: begin
                  if (cmd_pw_master && level_max_reg) begin
                    abort_next = 1'b1;
                  end else if (!cmd_pw_match) begin
                    abort_next = 1'b1;
                    mismatch = 1'b1;
                  end else begin
                    user_pw_next = 1'b0;
                  end
                end
                default: begin
                  exec_next = 1'b1;
                end
              endcase
            end
          end
        end
        default: begin
          mode_next = DSLG_BOOT;
        end
      endcase
    end
  end

  // Power-on reset holds the shipping defaults until the stored settings load.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= DSLG_BOOT;
      frozen_reg <= 1'b0;
      user_pw_reg <= 1'b0;
      level_max_reg <= 1'b0;
      rev_reg <= REV_DEFAULT;
      armed_reg <= 1'b0;
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
      exec_reg <= 1'b0;
      erase_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      frozen_reg <= frozen_next;
      user_pw_reg <= user_pw_next;
      level_max_reg <= level_max_next;
      rev_reg <= rev_next;
      armed_reg <= armed_next;
      done_reg <= done_next;
      abort_reg <= abort_next;
      exec_reg <= exec_next;
      erase_reg <= erase_next;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign cmd_done = done_reg;
  assign cmd_abort = abort_reg;
  assign cmd_exec = exec_reg;
  assign erase_start = erase_reg;
  assign mode_locked = mode_reg[1]; // The one-hot locked code lives in bit 1.
  assign mode_frozen = frozen_reg;
  assign user_pw_set = user_pw_reg;
  assign level_max = level_max_reg;
  assign id_word92 = rev_reg;
  assign unlock_attempts_exhausted_flag = expired;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic live;
  assign live = cmd_valid && !hard_rst_req && mode_reg != DSLG_BOOT;

  opcode_decode_a: assert property (
    live && cmd_opcode == OPC_FREEZE && mode_reg == DSLG_UNLOCKED |=> !cmd_exec)
    else $error("Freeze lock was passed on as an ordinary command.");
  boot_locks_a: assert property (
    mode_reg == DSLG_BOOT && !hard_rst_req && nv_user_pw_set |=> mode_locked)
    else $error("Device with user password did not come up locked.");
  unlocked_exec_a: assert property (
    live && mode_reg == DSLG_UNLOCKED && !frozen_reg && cmd_opcode == OPC_READ_DMA
    |=> cmd_exec && !cmd_abort)
    else $error("Unlocked device refused a media command.");
  frozen_sticky_a: assert property (mode_frozen |=> mode_frozen [*2])
    else $error("Frozen mode was left without power removal.");
  master_high_a: assert property (
    live && mode_locked && !level_max && cmd_opcode == OPC_UNLOCK && cmd_pw_master
    && cmd_pw_match && !expired |=> !mode_locked && !cmd_abort)
    else $error("Master password failed to unlock at high level.");
  master_max_a: assert property (
    live && mode_locked && level_max && cmd_opcode == OPC_UNLOCK && cmd_pw_master
    |=> cmd_abort && mode_locked)
    else $error("Master unlock succeeded at maximum level.");
  master_nolock_a: assert property (
    live && cmd_opcode == OPC_SET_PW && cmd_pw_master |=> $stable(user_pw_set))
    else $error("Setting the master password changed the lock.");
  rev_range_a: assert property (id_word92 >= REV_MIN && id_word92 <= REV_MAX)
    else $error("Revision code left its valid range.");
  hard_relock_a: assert property (
    hard_rst_req && mode_reg != DSLG_BOOT |=> mode_locked == $past(user_pw_set))
    else $error("Hard reset did not follow the lock enable.");
  expired_abort_a: assert property (
    live && expired && cmd_opcode == OPC_ERASE_UNIT |=> cmd_abort && !erase_start)
    else $error("Erase unit ran after attempts ran out.");
  locked_media_a: assert property (
    live && mode_locked && cmd_opcode == OPC_WRITE_DMA |=> cmd_abort && !cmd_exec && mode_locked)
    else $error("Locked device let a media write through.");
  frozen_filter_a: assert property (
    live && !mode_locked && frozen_reg && cmd_opcode == OPC_SET_PW |=> cmd_abort)
    else $error("Frozen device accepted set password.");
  abort_clean_a: assert property (
    cmd_abort && !$past(hard_rst_req) |-> $stable(mode_locked) && $stable(user_pw_set)
    && !erase_start && !cmd_exec)
    else $error("Aborted command changed the security state.");

  freeze_c: cover property (live && cmd_opcode == OPC_FREEZE ##1 mode_frozen);
  unlock_c: cover property (mode_locked ##1 !mode_locked);
  unlock_attempts_exhausted_flag_c: cover property (!expired ##1 expired);
  erase_c: cover property (erase_start);

endmodule

/* File: tb/dslg_host_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Host controller stand-in: one command per call, answer latched one clock later.
module dslg_host_model (
  // Clock.
  input wire logic ref_clk,
  // Command to the drive.
  output logic cmd_valid,
  output logic [dslg_pkg::OPC_W-1:0] cmd_opcode,
  output logic [dslg_pkg::OPC_W-1:0] cmd_feature,
  output logic cmd_pw_master,
  output logic cmd_level_max,
  output logic [dslg_pkg::REV_W-1:0] cmd_master_rev,
  output logic cmd_pw_match,
  // Answer from the drive.
  input wire logic cmd_done,
  input wire logic cmd_abort,
  input wire logic cmd_exec,
  input wire logic erase_start
);
  import dslg_pkg::*;
  logic [3:0] ans;

  // Idle bus at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_feature = 8'h00;
    cmd_pw_master = 1'b0;
    cmd_level_max = 1'b0;
    cmd_master_rev = 16'h0000;
    cmd_pw_match = 1'b0;
    ans = 4'h0;
  end

  // The fields other than cmd_level_max are inverted once the strobe drops, so a design that samples
  // them outside the strobe sees garbage rather than a lucky stale value.
  task automatic issue(input logic [7:0] op, input logic [7:0] feat, input logic mst,
                       input logic lvl, input logic [15:0] rev, input logic match);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_feature = feat;
    cmd_pw_master = mst;
    cmd_level_max = lvl;
    cmd_master_rev = rev;
    cmd_pw_match = match;
    @(posedge ref_clk);
    @(negedge ref_clk);
    ans = {cmd_done, cmd_abort, cmd_exec, erase_start};
    cmd_valid = 1'b0;
    cmd_opcode = ~op;
    cmd_feature = ~feat;
    cmd_pw_master = ~mst;
    cmd_master_rev = ~rev;
    cmd_pw_match = ~match;
  endtask
endmodule

/* File: tb/dslg_gate_tb_top.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module dslg_gate_tb_top;
  import dslg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hard_rst_req = 1'b0;
  logic nv_user_pw_set = 1'b0;
  logic nv_level_max = 1'b0;
  logic [15:0] nv_master_rev = 16'hfffe;
  logic cmd_valid, cmd_pw_master, cmd_level_max, cmd_pw_match;
  logic [7:0] cmd_opcode, cmd_feature;
  logic [15:0] cmd_master_rev, id_word92;
  logic cmd_done, cmd_abort, cmd_exec, erase_start;
  logic mode_locked, mode_frozen, user_pw_set, level_max, unlock_attempts_exhausted_flag;
  logic lvl_sel = 1'b0;
  logic [15:0] rev_sel = 16'h0000;
  int err_total = 0;
  int comparisons = 0;
  localparam logic [7:0] LOCK_OPS [29] = '{8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26,
    8'h29, 8'h2f, 8'h30, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3f, 8'h40, 8'h42, 8'h50,
    8'ha2, 8'hc4, 8'hc5, 8'hc7, 8'hc8, 8'hca, 8'hcc, 8'hf9, 8'hf1, 8'hf6, 8'hf5};

  // 25 MHz clock.
  always #20 ref_clk = ~ref_clk;

  dslg_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_feature(cmd_feature), .cmd_pw_master(cmd_pw_master), .cmd_level_max(cmd_level_max),
    .cmd_master_rev(cmd_master_rev), .cmd_pw_match(cmd_pw_match), .cmd_done(cmd_done),
    .cmd_abort(cmd_abort), .cmd_exec(cmd_exec), .erase_start(erase_start));

  dslg_gate uut (.ref_clk(ref_clk), .rst(rst), .hard_rst_req(hard_rst_req),
    .nv_user_pw_set(nv_user_pw_set), .nv_level_max(nv_level_max),
    .nv_master_rev(nv_master_rev), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_feature(cmd_feature), .cmd_pw_master(cmd_pw_master), .cmd_level_max(cmd_level_max),
    .cmd_master_rev(cmd_master_rev), .cmd_pw_match(cmd_pw_match), .cmd_done(cmd_done),
    .cmd_abort(cmd_abort), .cmd_exec(cmd_exec), .erase_start(erase_start),
    .mode_locked(mode_locked), .mode_frozen(mode_frozen), .user_pw_set(user_pw_set),
    .level_max(level_max), .id_word92(id_word92),
    .unlock_attempts_exhausted_flag(unlock_attempts_exhausted_flag));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Only non-security opcodes are handed on to the rest of the drive.
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic mst,
                     input logic match, input logic ab);
    host.issue(op, ft, mst, lvl_sel, rev_sel, match);
    check("cmd_done", host.ans[3], 1'b1);
    check("cmd_abort", host.ans[2], ab);
    check("cmd_exec", host.ans[1], !ab && !(op inside {[8'hf1:8'hf6]}));
    check("erase_start", host.ans[0], op == 8'hf4 && !ab);
    @(negedge ref_clk);
    check("cmd_done drop", cmd_done, 1'b0);
  endtask

  task automatic power_on(input logic pw, input logic mx, input logic [15:0] rev);
    @(negedge ref_clk);
    rst = 1'b1;
    nv_user_pw_set = pw;
    nv_level_max = mx;
    nv_master_rev = rev;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic hard_reset();
    @(negedge ref_clk);
    hard_rst_req = 1'b1;
    @(negedge ref_clk);
    hard_rst_req = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_boot();
    check("locked", mode_locked, 1'b0);
    check("word92", id_word92, 16'hfffe);
    check("flag", unlock_attempts_exhausted_flag, 1'b0);
    foreach (LOCK_OPS[i]) if (LOCK_OPS[i] < 8'hf1) cmd(LOCK_OPS[i], 8'h00, 1'b0, 1'b1, 1'b0);
    cmd(8'hb1, 8'hc3, 1'b0, 1'b1, 1'b0);
  endtask

  // The master password goes in first, before any user lock exists.
  task automatic t_master();
    rev_sel = 16'h1234;
    cmd(8'hf1, 8'h00, 1'b1, 1'b1, 1'b0);
    check("user_pw_set", user_pw_set, 1'b0);
    check("word92", id_word92, 16'h1234);
    rev_sel = 16'h0000;
    cmd(8'hf1, 8'h00, 1'b1, 1'b1, 1'b0);
    check("word92 kept", id_word92, 16'h1234);
    hard_reset();
    check("locked", mode_locked, 1'b0);
  endtask

  task automatic t_user_lock();
    cmd(8'hf1, 8'h00, 1'b0, 1'b1, 1'b0);
    check("user_pw_set", user_pw_set, 1'b1);
    check("locked early", mode_locked, 1'b0);
    hard_reset();
    check("locked", mode_locked, 1'b1);
    foreach (LOCK_OPS[i]) cmd(LOCK_OPS[i], 8'h00, 1'b0, 1'b1, 1'b1);
    cmd(8'hb1, 8'hc0, 1'b0, 1'b1, 1'b1);
    cmd(8'hb1, 8'hc3, 1'b0, 1'b1, 1'b1);
    check("still locked", mode_locked, 1'b1);
    check("not frozen", mode_frozen, 1'b0);
    cmd(8'hb1, 8'hc2, 1'b0, 1'b1, 1'b0);
    cmd(8'hec, 8'h00, 1'b0, 1'b1, 1'b0);
    cmd(8'hf8, 8'h00, 1'b0, 1'b1, 1'b0);
    cmd(8'hf2, 8'h00, 1'b1, 1'b1, 1'b0);
    check("master unlock", mode_locked, 1'b0);
    cmd(8'hf6, 8'h00, 1'b0, 1'b1, 1'b0);
    check("pw disabled", user_pw_set, 1'b0);
    cmd(8'hf1, 8'h00, 1'b0, 1'b1, 1'b0);
    check("pw again", user_pw_set, 1'b1);
  endtask

  task automatic t_attempts();
    hard_reset();
    repeat (4) cmd(8'hf2, 8'h00, 1'b0, 1'b0, 1'b1);
    check("flag at 4", unlock_attempts_exhausted_flag, 1'b0);
    cmd(8'hf2, 8'h00, 1'b1, 1'b0, 1'b1);
    check("flag at 5", unlock_attempts_exhausted_flag, 1'b1);
    cmd(8'hf2, 8'h00, 1'b0, 1'b1, 1'b1);
    cmd(8'hf3, 8'h00, 1'b1, 1'b1, 1'b0);
    cmd(8'hf4, 8'h00, 1'b1, 1'b1, 1'b1);
    check("flag kept", unlock_attempts_exhausted_flag, 1'b1);
    check("locked", mode_locked, 1'b1);
    hard_reset();
    check("flag cleared", unlock_attempts_exhausted_flag, 1'b0);
    cmd(8'hf2, 8'h00, 1'b0, 1'b1, 1'b0);
    check("unlocked", mode_locked, 1'b0);
  endtask

  task automatic t_max();
    lvl_sel = 1'b1;
    cmd(8'hf1, 8'h00, 1'b0, 1'b1, 1'b0);
    check("level_max", level_max, 1'b1);
    hard_reset();
    cmd(8'hf4, 8'h00, 1'b1, 1'b1, 1'b1);
    cmd(8'hf2, 8'h00, 1'b1, 1'b1, 1'b1);
    cmd(8'hf3, 8'h00, 1'b1, 1'b1, 1'b0);
    cmd(8'hf4, 8'h00, 1'b1, 1'b1, 1'b0);
    check("erase_start", host.ans[0], 1'b1);
    check("locked", mode_locked, 1'b0);
    check("user_pw_set", user_pw_set, 1'b0);
  endtask

  task automatic t_freeze();
    cmd(8'hf5, 8'h00, 1'b0, 1'b1, 1'b0);
    check("frozen", mode_frozen, 1'b1);
    for (int op = 8'hf1; op <= 8'hf6; op++) if (op != 8'hf5) cmd(op[7:0], 8'h00, 1'b0, 1'b1, 1'b1);
    cmd(8'hc8, 8'h00, 1'b0, 1'b1, 1'b0);
    hard_reset();
    check("frozen kept", mode_frozen, 1'b1);
    power_on(1'b1, 1'b1, 16'h0042);
    check("frozen off", mode_frozen, 1'b0);
    check("locked", mode_locked, 1'b1);
    check("level_max", level_max, 1'b1);
    check("word92", id_word92, 16'h0042);
    cmd(8'hc8, 8'h00, 1'b0, 1'b1, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and a watchdog in case the run hangs.
  initial begin
    power_on(1'b0, 1'b0, 16'hfffe);
    t_boot();
    t_master();
    t_user_lock();
    t_attempts();
    t_max();
    t_freeze();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
